// file: rtl/brf_defines.svh
// brf_defines.svh: offsets, field positions and reset values of the block ram fifo pair
// assumes: included by brf_block_ram, brf_user_ctrl and the bench by bare name
`ifndef BRF_DEFINES_SVH
`define BRF_DEFINES_SVH

// =====================================================================
// controller register byte offsets (apb)
`define BRF_OFF_CTRL    12'h000
`define BRF_OFF_THR_FF  12'h004
`define BRF_OFF_THR_AF  12'h008
`define BRF_OFF_THR_AE  12'h00C
`define BRF_OFF_ADDR    12'h010
`define BRF_OFF_WDATA   12'h014
`define BRF_OFF_CMD     12'h018
`define BRF_OFF_RDATA   12'h01C
`define BRF_OFF_STATUS  12'h020
`define BRF_OFF_DOUTA   12'h024

// =====================================================================
// field positions
`define BRF_CTRL_FIFO   0
`define BRF_CTRL_WM_LO  1
`define BRF_CTRL_CLRA   3
`define BRF_CTRL_CLRB   4
`define BRF_ADDR_B_LO   16
`define BRF_CMD_FRST    0
`define BRF_CMD_RPCLR   1
`define BRF_CMD_GCLR    2
`define BRF_CMD_POP     3
`define BRF_CMD_RDA     4
`define BRF_ST_BUSY     4

// =====================================================================
// reset values and fixed thresholds
`define BRF_EMPTY_THR   0
`define BRF_MIN_THR     1
`define BRF_THR_FF_RST  32'h0000000F
`define BRF_THR_AF_RST  32'h0000000C
`define BRF_THR_AE_RST  32'h00000003

`endif

// file: rtl/brf_pkg.sv
// brf_pkg: types shared by both ends of the block ram fifo link
// assumes: brf_defines.svh holds the numeric constants
package brf_pkg;
    // =================================================================
    // write behaviour of the ram write port
    typedef enum logic [1:0] {
        BRF_WM_NORMAL,
        BRF_WM_THROUGH,
        BRF_WM_RBW
    } brf_wmode_t;

    // =================================================================
    // controller sequencer states
    typedef enum logic [2:0] {
        BRF_S_IDLE,
        BRF_S_WR,
        BRF_S_RDA,
        BRF_S_RDB,
        BRF_S_PRE,
        BRF_S_RST,
        BRF_S_POST
    } brf_seq_t;
endpackage : brf_pkg

// file: rtl/brf_link_if.sv
// brf_link_if: signals between the block ram fifo and the user logic
// assumes: both ends run on pclk; the bench instantiates and joins them
`timescale 1ns/1ps
interface brf_link_if #(
    parameter int DW = 8,
    parameter int AW = 4
) (
    input wire logic pclk,
    input wire logic presetn
);
    import brf_pkg::*;
    // configuration
    logic              fifo_mode;
    brf_wmode_t        write_mode;
    logic [AW-1:0]     full_thresh;
    logic [AW-1:0]     afull_thresh;
    logic [AW-1:0]     aempty_thresh;
    // write port
    logic              wr_clock_en;
    logic              wr_en;
    logic [AW-1:0]     addr_a;
    logic [DW-1:0]     din;
    logic [DW-1:0]     dout_a;
    // read port
    logic              rd_clock_en;
    logic              rd_strobe;
    logic [AW-1:0]     addr_b;
    logic [DW-1:0]     dout_b;
    // flags
    logic              full_flag;
    logic              almost_full_flag;
    logic              almost_empty_flag;
    logic              empty_flag;
    // resets
    logic              fifo_reset;
    logic              read_pointer_clear;
    logic              port_a_latch_clear;
    logic              port_b_latch_clear;
    logic              global_clear_n;

    modport dev (
        input  pclk, presetn, fifo_mode, write_mode, full_thresh, afull_thresh,
               aempty_thresh, wr_clock_en, wr_en, addr_a, din, rd_clock_en,
               rd_strobe, addr_b, fifo_reset, read_pointer_clear,
               port_a_latch_clear, port_b_latch_clear, global_clear_n,
        output dout_a, dout_b, full_flag, almost_full_flag, almost_empty_flag,
               empty_flag
    );
    modport usr (
        input  pclk, presetn, dout_a, dout_b, full_flag, almost_full_flag,
               almost_empty_flag, empty_flag,
        output fifo_mode, write_mode, full_thresh, afull_thresh, aempty_thresh,
               wr_clock_en, wr_en, addr_a, din, rd_clock_en, rd_strobe, addr_b,
               fifo_reset, read_pointer_clear, port_a_latch_clear,
               port_b_latch_clear, global_clear_n
    );
endinterface : brf_link_if

// file: rtl/brf_block_ram.sv
// brf_block_ram: dual port block ram with three write behaviours and a fifo mode
// assumes: the user end sequences clock enables around asynchronous resets
`timescale 1ns/1ps
module brf_block_ram #(
    parameter int DW              = 8,
    parameter int AW              = 4,
    parameter bit ASYNC_CLEAR_A   = 1'b0,
    parameter bit ASYNC_CLEAR_B   = 1'b0
) (
    // link to the user logic
    brf_link_if.dev link
);
    import brf_pkg::*;
    `include "brf_defines.svh"

    // =================================================================
    // elaboration checks
    generate
        if (DW < 1 || AW < 2 || AW > 16) begin : g_bad_param
            $error("brf_block_ram: DW must be >= 1 and AW within 2..16");
        end
    endgenerate

    localparam int DEPTH = 1 << AW;

    // =================================================================
    // threshold clamp, used for every programmable flag level
    function automatic logic [AW:0] clamp_thr(input logic [AW:0] v,
                                              input logic [AW:0] hi);
        logic [AW:0] r;
        r = v;
        // ceiling first, then floor: a full level of 1 pins the almost levels at 1
        if (r > hi)
            r = hi;
        if (r < (AW+1)'(`BRF_MIN_THR))
            r = (AW+1)'(`BRF_MIN_THR);
        return r;
    endfunction : clamp_thr

    // =================================================================
    // storage and reset nets
    logic [DW-1:0]  mem [DEPTH];
    logic           rst_n;
    logic           fifo_clr;
    logic           rptr_clr;
    logic           aclr_a;
    logic           aclr_b;

    // global clear and apb reset both act asynchronously
    assign rst_n    = link.presetn & link.global_clear_n;
    assign fifo_clr = link.fifo_reset;
    assign rptr_clr = link.fifo_reset | link.read_pointer_clear;
    // latch clears only reach the async pins when so configured
    assign aclr_a   = ASYNC_CLEAR_A & link.port_a_latch_clear;
    assign aclr_b   = ASYNC_CLEAR_B & link.port_b_latch_clear;

    // =================================================================
    // pointers, count and thresholds
    logic [AW:0]    wptr_reg;
    logic [AW:0]    rptr_reg;
    logic [AW:0]    wptr_next;
    logic [AW:0]    rptr_next;
    logic [AW:0]    cnt_next;
    logic [AW:0]    thr_ff;
    logic [AW:0]    thr_af;
    logic [AW:0]    thr_ae;
    logic           full_reg;
    logic           afull_reg;
    logic           empty_reg;
    logic           aempty_reg;
    logic           push;
    logic           pop;

    // full is capped at depth-1 by its width; almost levels below full unless full is 1
    assign thr_ff = clamp_thr({1'b0, link.full_thresh},
                              (AW+1)'(DEPTH - 1));
    assign thr_af = clamp_thr({1'b0, link.afull_thresh},
                              thr_ff - (AW+1)'(1));
    assign thr_ae = clamp_thr({1'b0, link.aempty_thresh},
                              thr_ff - (AW+1)'(1));

    // write and read enables gate the fifo like clock enables
    assign push = link.fifo_mode & link.wr_clock_en & link.wr_en
                  & ~full_reg;
    assign pop  = link.fifo_mode & link.rd_clock_en & link.rd_strobe
                  & ~empty_reg;

    assign wptr_next = push ? wptr_reg + (AW+1)'(1) : wptr_reg;
    assign rptr_next = pop  ? rptr_reg + (AW+1)'(1) : rptr_reg;
    assign cnt_next  = wptr_next - rptr_next;

    // write pointer: cleared only by the whole-fifo reset, the global clear and the apb reset
    always_ff @(posedge link.pclk or negedge rst_n or posedge fifo_clr) begin
        if (!rst_n) begin
            wptr_reg <= '0;
        end else if (fifo_clr) begin
            wptr_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
        end
    end

    // read pointer: the separate clear rewinds it for retransmission
    always_ff @(posedge link.pclk or negedge rst_n or posedge rptr_clr) begin
        if (!rst_n) begin
            rptr_reg <= '0;
        end else if (rptr_clr) begin
            rptr_reg <= '0;
        end else begin
            rptr_reg <= rptr_next;
        end
    end

    // write-side flags; the count is rebuilt from the next pointers so
    // the flag is exact on the edge after the access
    always_ff @(posedge link.pclk or negedge rst_n or posedge fifo_clr) begin
        if (!rst_n) begin
            full_reg  <= 1'b0;
            afull_reg <= 1'b0;
        end else if (fifo_clr) begin
            full_reg  <= 1'b0;
            afull_reg <= 1'b0;
        end else begin
            full_reg  <= (cnt_next >= thr_ff);
            afull_reg <= (cnt_next >= thr_af);
        end
    end

    // read-side flags; a read pointer rewind is seen through cnt_next,
    // so the edge during the rewind already shows the restored count
    always_ff @(posedge link.pclk or negedge rst_n or posedge fifo_clr) begin
        if (!rst_n) begin
            empty_reg  <= 1'b1;
            aempty_reg <= 1'b1;
        end else if (fifo_clr) begin
            empty_reg  <= 1'b1;
            aempty_reg <= 1'b1;
        end else begin
            empty_reg  <= (cnt_next == (AW+1)'(`BRF_EMPTY_THR));
            aempty_reg <= (cnt_next <= thr_ae);
        end
    end

    assign link.full_flag         = full_reg;
    assign link.almost_full_flag  = afull_reg;
    assign link.empty_flag        = empty_reg;
    assign link.almost_empty_flag = aempty_reg;

    // =================================================================
    // memory array; no reset so it maps onto block ram
    logic [AW-1:0]  wa;
    logic [AW-1:0]  ra;
    logic           ram_we;

    assign wa     = link.fifo_mode ? wptr_reg[AW-1:0] : link.addr_a;
    assign ra     = link.fifo_mode ? rptr_reg[AW-1:0] : link.addr_b;
    assign ram_we = link.fifo_mode ? push : (link.wr_clock_en & link.wr_en);

    always_ff @(posedge link.pclk) begin
        if (ram_we) begin
            mem[wa] <= link.din;
        end
    end

    // =================================================================
    // port a output latch: write behaviour decides what a write shows
    logic [DW-1:0]  douta_reg;
    logic [DW-1:0]  doutb_reg;

    always_ff @(posedge link.pclk or negedge rst_n or posedge aclr_a) begin
        if (!rst_n) begin
            douta_reg <= '0;
        end else if (aclr_a) begin
            douta_reg <= '0;
        end else if (!ASYNC_CLEAR_A && link.port_a_latch_clear) begin
            douta_reg <= '0;
        end else if (!link.fifo_mode && link.wr_clock_en) begin
            if (!link.wr_en) begin
                douta_reg <= mem[wa];
            end else begin
                case (link.write_mode)
                    BRF_WM_NORMAL:  douta_reg <= douta_reg;
                    BRF_WM_THROUGH: douta_reg <= link.din;
                    BRF_WM_RBW:     douta_reg <= mem[wa];
                    default:        douta_reg <= douta_reg;
                endcase
            end
        end
    end

    // port b output latch: ram read or fifo pop; in fifo mode a read
    // on empty leaves the last word in place
    always_ff @(posedge link.pclk or negedge rst_n or posedge aclr_b) begin
        if (!rst_n) begin
            doutb_reg <= '0;
        end else if (aclr_b) begin
            doutb_reg <= '0;
        end else if (!ASYNC_CLEAR_B && link.port_b_latch_clear) begin
            doutb_reg <= '0;
        end else if (pop) begin
            doutb_reg <= mem[ra];
        end else if (!link.fifo_mode && link.rd_clock_en) begin
            doutb_reg <= mem[ra];
        end
    end

    assign link.dout_a = douta_reg;
    assign link.dout_b = doutb_reg;

endmodule : brf_block_ram

// file: rtl/brf_user_ctrl.sv
// brf_user_ctrl: apb-programmed user logic that drives the block ram fifo
// assumes: apb master on pclk; device joined through brf_link_if
`timescale 1ns/1ps
module brf_user_ctrl #(
    parameter int DW = 8,
    parameter int AW = 4
) (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // link to the block ram
    brf_link_if.usr          link
);
    import brf_pkg::*;
    `include "brf_defines.svh"

    generate
        if (DW < 1 || DW > 32 || AW < 2 || AW > 16) begin : g_bad_param
            $error("brf_user_ctrl: DW within 1..32, AW within 2..16");
        end
    endgenerate

    // =================================================================
    // apb handshake: zero wait, ready in the first access cycle
    logic        wr_acc;
    logic        rd_acc;
    logic [31:0] ctrl_reg;
    logic [31:0] thr_ff_reg;
    logic [31:0] thr_af_reg;
    logic [31:0] thr_ae_reg;
    logic [31:0] addr_reg;
    logic [DW-1:0] din_reg;
    logic [DW-1:0] rdata_reg;
    brf_seq_t    st_reg;
    logic [2:0]  kind_reg;
    logic        wen_reg;
    logic        wce_reg;
    logic        rce_reg;
    logic        frst_reg;
    logic        rpclr_reg;
    logic        gclr_n_reg;
    logic        idle;

    assign wr_acc = psel & penable & pready & pwrite;
    assign rd_acc = psel & ~penable & ~pwrite;
    assign idle   = (st_reg == BRF_S_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > `BRF_OFF_DOUTA);
        end
    end

    // read data captured in the setup cycle; unmapped reads return zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_acc) begin
            case (paddr)
                `BRF_OFF_CTRL:   prdata <= ctrl_reg;
                `BRF_OFF_THR_FF: prdata <= thr_ff_reg;
                `BRF_OFF_THR_AF: prdata <= thr_af_reg;
                `BRF_OFF_THR_AE: prdata <= thr_ae_reg;
                `BRF_OFF_ADDR:   prdata <= addr_reg;
                `BRF_OFF_WDATA:  prdata <= 32'(din_reg);
                `BRF_OFF_RDATA:  prdata <= 32'(rdata_reg);
                `BRF_OFF_STATUS: prdata <= {27'h0000000, ~idle,
                                            link.empty_flag, link.almost_empty_flag,
                                            link.almost_full_flag, link.full_flag};
                `BRF_OFF_DOUTA:  prdata <= 32'(link.dout_a);
                default:         prdata <= '0;
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= '0;
            thr_ff_reg <= `BRF_THR_FF_RST;
            thr_af_reg <= `BRF_THR_AF_RST;
            thr_ae_reg <= `BRF_THR_AE_RST;
            addr_reg   <= '0;
        end else if (wr_acc) begin
            case (paddr)
                `BRF_OFF_CTRL:   ctrl_reg   <= pwdata;
                `BRF_OFF_THR_FF: thr_ff_reg <= pwdata;
                `BRF_OFF_THR_AF: thr_af_reg <= pwdata;
                `BRF_OFF_THR_AE: thr_ae_reg <= pwdata;
                `BRF_OFF_ADDR:   addr_reg   <= pwdata;
                default:         ctrl_reg   <= ctrl_reg;
            endcase
        end
    end

    // =================================================================
    // sequencer: one op at a time; commands while busy are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg     <= BRF_S_IDLE;
            kind_reg   <= '0;
            din_reg    <= '0;
            rdata_reg  <= '0;
            wen_reg    <= 1'b0;
            wce_reg    <= 1'b0;
            rce_reg    <= 1'b0;
            frst_reg   <= 1'b0;
            rpclr_reg  <= 1'b0;
            gclr_n_reg <= 1'b1;
        end else begin
            case (st_reg)
                BRF_S_IDLE: begin
                    if (wr_acc && paddr == `BRF_OFF_WDATA) begin
                        din_reg <= pwdata[DW-1:0];
                        wce_reg <= 1'b1;
                        wen_reg <= 1'b1;
                        st_reg  <= BRF_S_WR;
                    end else if (wr_acc && paddr == `BRF_OFF_CMD) begin
                        if (|pwdata[`BRF_CMD_GCLR:`BRF_CMD_FRST]) begin
                            // enables are already low in idle
                            kind_reg <= pwdata[`BRF_CMD_GCLR:`BRF_CMD_FRST];
                            st_reg   <= BRF_S_PRE;
                        end else if (pwdata[`BRF_CMD_POP]) begin
                            rce_reg <= 1'b1;
                            st_reg  <= BRF_S_RDA;
                        end else if (pwdata[`BRF_CMD_RDA]) begin
                            wce_reg <= 1'b1;
                            st_reg  <= BRF_S_WR;
                        end
                    end
                end
                BRF_S_WR: begin
                    wce_reg <= 1'b0;
                    wen_reg <= 1'b0;
                    st_reg  <= BRF_S_IDLE;
                end
                BRF_S_RDA: begin
                    rce_reg <= 1'b0;
                    st_reg  <= BRF_S_RDB;
                end
                BRF_S_RDB: begin
                    rdata_reg <= link.dout_b;
                    st_reg    <= BRF_S_IDLE;
                end
                BRF_S_PRE: begin
                    // one quiet cycle has passed; assert the resets
                    frst_reg   <= kind_reg[0];
                    rpclr_reg  <= kind_reg[1];
                    gclr_n_reg <= ~kind_reg[2];
                    st_reg     <= BRF_S_RST;
                end
                BRF_S_RST: begin
                    // release with a full period of setup before any enable
                    frst_reg   <= 1'b0;
                    rpclr_reg  <= 1'b0;
                    gclr_n_reg <= 1'b1;
                    st_reg     <= BRF_S_POST;
                end
                BRF_S_POST: begin
                    st_reg <= BRF_S_IDLE;
                end
                default: st_reg <= BRF_S_IDLE;
            endcase
        end
    end

    // =================================================================
    // link drive; latch clears are plain synchronous levels
    assign link.fifo_mode          = ctrl_reg[`BRF_CTRL_FIFO];
    assign link.write_mode         = brf_wmode_t'(ctrl_reg[`BRF_CTRL_WM_LO+1:`BRF_CTRL_WM_LO]);
    assign link.port_a_latch_clear = ctrl_reg[`BRF_CTRL_CLRA];
    assign link.port_b_latch_clear = ctrl_reg[`BRF_CTRL_CLRB];
    assign link.full_thresh        = thr_ff_reg[AW-1:0];
    assign link.afull_thresh       = thr_af_reg[AW-1:0];
    assign link.aempty_thresh      = thr_ae_reg[AW-1:0];
    assign link.addr_a             = addr_reg[AW-1:0];
    assign link.addr_b             = addr_reg[`BRF_ADDR_B_LO+AW-1:`BRF_ADDR_B_LO];
    assign link.din                = din_reg;
    assign link.wr_clock_en        = wce_reg;
    assign link.wr_en              = wen_reg;
    assign link.rd_clock_en        = rce_reg;
    assign link.rd_strobe          = rce_reg;
    assign link.fifo_reset         = frst_reg;
    assign link.read_pointer_clear = rpclr_reg;
    assign link.global_clear_n     = gclr_n_reg;

endmodule : brf_user_ctrl

// file: sim/brf_link_asserts.sv
// brf_link_asserts: timing checks on the link between the fifo pair
// assumes: the bench wires the link signals in by name, one clock pclk
`timescale 1ns/1ps
module brf_link_asserts #(parameter int DW = 8) (
    // clock and reset
    input wire logic          pclk,
    input wire logic          presetn,
    // user side strobes
    input wire logic          fifo_mode,
    input wire brf_pkg::brf_wmode_t write_mode,
    input wire logic [DW-1:0] din,
    input wire logic          wr_en,
    input wire logic          rd_strobe,
    input wire logic          fifo_reset,
    input wire logic          read_pointer_clear,
    input wire logic          global_clear_n,
    // device side results
    input wire logic [DW-1:0] dout_a,
    input wire logic [DW-1:0] dout_b,
    input wire logic          full_flag,
    input wire logic          almost_full_flag,
    input wire logic          almost_empty_flag,
    input wire logic          empty_flag
);
    import brf_pkg::*;
    // =================================================================
    // properties, all on pclk
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_gclr; !global_clear_n |-> dout_a == '0 && dout_b == '0; endproperty
    a_gclr: assert property (p_gclr) else $error("latches kept data");
    property p_frst; fifo_reset |-> empty_flag && !full_flag; endproperty
    a_frst: assert property (p_frst) else $error("flags not cleared");
    property p_thru; wr_en && !fifo_mode && write_mode == BRF_WM_THROUGH |=> dout_a == $past(din);
    endproperty
    a_thru: assert property (p_thru) else $error("written data not shown");
    property p_norm; wr_en && !fifo_mode && write_mode == BRF_WM_NORMAL |=> $stable(dout_a);
    endproperty
    a_norm: assert property (p_norm) else $error("output moved on write");
    property p_pop; rd_strobe && fifo_mode && !empty_flag |=> !full_flag; endproperty
    a_pop: assert property (p_pop) else $error("full after pop");
    property p_push; wr_en && fifo_mode && !full_flag |=> !empty_flag; endproperty
    a_push: assert property (p_push) else $error("empty after push");
    property p_ae; empty_flag |-> almost_empty_flag; endproperty
    a_ae: assert property (p_ae) else $error("empty without almost empty");
    property p_af; full_flag |-> almost_full_flag; endproperty
    a_af: assert property (p_af) else $error("full without almost full");
    // main scenarios reached
    c_full: cover property (full_flag && wr_en);
    c_rew: cover property (read_pointer_clear);
    c_gclr: cover property (!global_clear_n);
endmodule : brf_link_asserts

// file: sim/block_ram_fifo_with_resets_test.sv
// block_ram_fifo_with_resets_test: apb-driven bench for the fifo pair
// assumes: controller offsets and reset values from brf_defines.svh
`timescale 1ns/1ps
`include "brf_defines.svh"
module block_ram_fifo_with_resets_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, e;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    int miscompares = 0, tests_run = 0, cyc = 0;
    // ram rows: ctrl, target register, value, expected port a output
    logic [31:0] rc[4] = '{32'h2, 32'h4, 32'h0, 32'h0};
    logic [11:0] ra[4] = '{`BRF_OFF_WDATA, `BRF_OFF_WDATA, `BRF_OFF_WDATA, `BRF_OFF_CMD};
    logic [31:0] rv[4] = '{32'h5A, 32'hA5, 32'h3C, 32'h10};
    logic [31:0] rx[4] = '{32'h5A, 32'h5A, 32'h5A, 32'h3C};
    brf_link_if #(.DW(8), .AW(4)) link (.pclk(pclk), .presetn(presetn));
    brf_block_ram brf_block_ram_i (.link(link));
    brf_user_ctrl brf_user_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    brf_link_asserts brf_link_asserts_i (.pclk(pclk), .presetn(presetn),
        .fifo_mode(link.fifo_mode), .write_mode(link.write_mode), .din(link.din),
        .wr_en(link.wr_en), .rd_strobe(link.rd_strobe), .fifo_reset(link.fifo_reset),
        .read_pointer_clear(link.read_pointer_clear), .global_clear_n(link.global_clear_n),
        .dout_a(link.dout_a), .dout_b(link.dout_b), .full_flag(link.full_flag),
        .almost_full_flag(link.almost_full_flag), .almost_empty_flag(link.almost_empty_flag),
        .empty_flag(link.empty_flag));
    // =================================================================
    // clock and hang guard
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; pready, data and error taken at the rising edge
    // that ends the access, and the request released at that same edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // write then poll busy; first status read only lets busy settle
    task automatic op(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
        apb(0, `BRF_OFF_STATUS, 0);
        do apb(0, `BRF_OFF_STATUS, 0); while (q[`BRF_ST_BUSY] !== 1'b0);
    endtask : op
    task automatic rd(input logic [11:0] a);
        apb(0, a, 0);
    endtask : rd
    task automatic tally_and_finish();
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(`BRF_OFF_STATUS); chk(q, 32'hC);
        rd(`BRF_OFF_THR_FF); chk(q, `BRF_THR_FF_RST);
        rd(`BRF_OFF_THR_AF); chk(q, `BRF_THR_AF_RST);
        rd(`BRF_OFF_THR_AE); chk(q, `BRF_THR_AE_RST);
        op(`BRF_OFF_ADDR, 32'h3);
        for (int i = 0; i < 4; i++) begin
            op(`BRF_OFF_CTRL, rc[i]);
            op(ra[i], rv[i]);
            rd(`BRF_OFF_DOUTA); chk(q, rx[i]);
        end
        // port a latch clear, then data still in ram read back on port a
        op(`BRF_OFF_CTRL, 32'h8);
        rd(`BRF_OFF_DOUTA); chk(q, 32'h0);
        op(`BRF_OFF_CTRL, 32'h0);
        op(`BRF_OFF_CMD, 32'h10);
        rd(`BRF_OFF_DOUTA); chk(q, 32'h3C);
        // port b ram read, then its own clear leaves port a alone
        op(`BRF_OFF_ADDR, 32'h30003);
        op(`BRF_OFF_CMD, 32'h8);
        rd(`BRF_OFF_RDATA); chk(q, 32'h3C);
        op(`BRF_OFF_CTRL, 32'h10);
        op(`BRF_OFF_CMD, 32'h8);
        rd(`BRF_OFF_RDATA); chk(q, 32'h0);
        rd(`BRF_OFF_DOUTA); chk(q, 32'h3C);
        op(`BRF_OFF_CTRL, 32'h0);
        op(`BRF_OFF_CMD, 32'h4);
        rd(`BRF_OFF_DOUTA); chk(q, 32'h0);
        // fifo filled past full, drained in order
        op(`BRF_OFF_CTRL, 32'h1);
        op(`BRF_OFF_CMD, 32'h1);
        for (int i = 1; i <= 16; i++) op(`BRF_OFF_WDATA, i);
        rd(`BRF_OFF_STATUS); chk(q, 32'h3);
        for (int i = 1; i <= 15; i++) begin
            op(`BRF_OFF_CMD, 32'h8);
            rd(`BRF_OFF_RDATA); chk(q, i);
        end
        rd(`BRF_OFF_STATUS); chk(q, 32'hC);
        // retransmit after read pointer rewind
        op(`BRF_OFF_CMD, 32'h1);
        op(`BRF_OFF_WDATA, 32'h7);
        op(`BRF_OFF_WDATA, 32'h8);
        op(`BRF_OFF_CMD, 32'h8);
        op(`BRF_OFF_CMD, 32'h2);
        op(`BRF_OFF_CMD, 32'h8);
        rd(`BRF_OFF_RDATA); chk(q, 32'h7);
        rd(12'h040); chk({e, q[30:0]}, 32'h80000000);
        tally_and_finish();
    end
endmodule : block_ram_fifo_with_resets_test
